// File: rtl/rbs_cfg.svh
// Constants for the resolution burst sequencer.
// Included by the package and the sequencer; definitions only.
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH
// Register byte offsets
`define RBS_OFS_CTRL 4'h0
`define RBS_OFS_LEN 4'h4
`define RBS_OFS_STAT 4'h8
`define RBS_OFS_TRIG 4'hC
// Control field positions
`define RBS_CTRL_ENABLE 0
`define RBS_CTRL_WIDTH14 1
`define RBS_CTRL_TRIGMODE 2
`define RBS_CTRL_SOFTPU 3
// Phase length limits, as exponents of two
`define RBS_LEN_MIN_LOG2 10
`define RBS_LEN_MAX_LOG2 25
// Start-up delay loaded at reset is three minimum bursts
`define RBS_PWRUP_MULT 3
// Resolutions in bits
`define RBS_RES_LOW 9
`define RBS_RES_MID 12
`define RBS_RES_HIGH 14
`endif

// File: rtl/rbs_pkg.sv
// Types shared by the resolution burst sequencer and its bench.
// Assumes rbs_cfg.svh is on the include path.
`include "rbs_cfg.svh"
package rbs_pkg;
  typedef enum logic [2:0] {
    RBS_ST_OFF = 3'b001,
    RBS_ST_LOW = 3'b010,
    RBS_ST_HIGH = 3'b100
  } rbs_state_e;
  // Sample word with its resolution tag
  typedef struct packed {
    logic [13:0] data;
    logic [3:0] res_bits;
    logic high_res;
  } rbs_sample_s;
endpackage

// File: rtl/rbs_sequencer.sv
// Resolution burst sequencer: Avalon-MM slave, phase sequencer and output buffer.
// Assumes one sample per sys_clk step and a framer with valid/ready handshake.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "rbs_cfg.svh"
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int LEN_W = 26
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [13:0] adc_data,
  output logic out_valid,
  input wire logic out_ready,
  output rbs_sample_s out_sample
);
  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic enable;
  logic width14;
  logic trig_mode;
  logic [LEN_W-1:0] burst_phase_length;
  logic ack;
  logic next_enable;
  logic next_width14;
  logic next_trig_mode;
  logic [LEN_W-1:0] next_burst_phase_length;
  logic next_ack;
  logic restart;
  logic trig_req;
  logic startup_done;
  rbs_state_e state;
  logic [LEN_W+1:0] count;
  logic [LEN_W+1:0] burst_startup_delay;
  logic in_ready;
  localparam logic [LEN_W-1:0] LEN_MIN = LEN_W'(1) << `RBS_LEN_MIN_LOG2;
  localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(1) << `RBS_LEN_MAX_LOG2;
  // One wait state per access, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  // Register writes and reconfiguration events
  always_comb
  begin
    next_enable = enable;
    next_width14 = width14;
    next_trig_mode = trig_mode;
    next_burst_phase_length = burst_phase_length;
    next_ack = (avs_read | avs_write) & ~ack;
    restart = 1'b0;
    trig_req = 1'b0;
    if (avs_write && ack)
    begin
      case (avs_address)
        `RBS_OFS_CTRL:
        begin
          next_enable = avs_writedata[`RBS_CTRL_ENABLE];
          next_width14 = avs_writedata[`RBS_CTRL_WIDTH14];
          next_trig_mode = avs_writedata[`RBS_CTRL_TRIGMODE];
          // Restart start-up on soft power-up, width or trigger-mode change, or enable rising
          restart = avs_writedata[`RBS_CTRL_SOFTPU]
            | (avs_writedata[`RBS_CTRL_WIDTH14] != width14)
            | (avs_writedata[`RBS_CTRL_ENABLE] & ~enable)
            | (avs_writedata[`RBS_CTRL_TRIGMODE] != trig_mode);
        end
        `RBS_OFS_LEN:
        begin
          // Clamp into legal range
          if (avs_writedata < 32'(LEN_MIN)) // Whole word, so high bits still clamp
            next_burst_phase_length = LEN_MIN;
          else if (avs_writedata > 32'(LEN_MAX))
            next_burst_phase_length = LEN_MAX;
          else
            next_burst_phase_length = avs_writedata[LEN_W-1:0];
        end
        `RBS_OFS_TRIG: trig_req = avs_writedata[0];
        default: ;
      endcase
    end
  end
  // Register state
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      enable <= 1'b0;
      width14 <= 1'b1;
      trig_mode <= 1'b0;
      burst_phase_length <= LEN_MIN;
      ack <= 1'b0;
    end
    else
    begin
      enable <= next_enable;
      width14 <= next_width14;
      trig_mode <= next_trig_mode;
      burst_phase_length <= next_burst_phase_length;
      ack <= next_ack;
    end
  end
  // Read mux, unmapped reads return zero
  always_comb
  begin
    avs_readdata = 32'h0000_0000;
    case (avs_address)
      `RBS_OFS_CTRL:
      begin
        avs_readdata[`RBS_CTRL_ENABLE] = enable;
        avs_readdata[`RBS_CTRL_WIDTH14] = width14;
        avs_readdata[`RBS_CTRL_TRIGMODE] = trig_mode;
      end
      `RBS_OFS_LEN: avs_readdata[LEN_W-1:0] = burst_phase_length;
      `RBS_OFS_STAT: avs_readdata[4:0] = {startup_done, out_valid, state};
      default: ;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  rbs_state_e next_state;
  logic [LEN_W+1:0] next_count;
  logic next_startup_done;
  logic [LEN_W+1:0] next_burst_startup_delay;
  logic [LEN_W+1:0] low_len;
  logic trig_pend;
  logic next_trig_pend;
  // Low length from the width in force next cycle
  assign low_len = next_width14 ? ((LEN_W+2)'(burst_phase_length) * (LEN_W+2)'(3))
                                : (LEN_W+2)'(burst_phase_length);
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_startup_done = startup_done;
    next_burst_startup_delay = burst_startup_delay;
    next_trig_pend = trig_pend;
    if (restart)
    begin
      // Delay of one low phase after reconfiguration
      next_state = next_enable ? RBS_ST_LOW : RBS_ST_OFF;
      next_count = '0;
      next_startup_done = 1'b0;
      next_trig_pend = 1'b0;
      next_burst_startup_delay = low_len;
    end
    else if (in_ready)
    begin
      case (state)
        RBS_ST_OFF:
        begin
          next_count = '0;
          if (enable)
            next_state = RBS_ST_LOW;
        end
        RBS_ST_LOW:
        begin
          if (!startup_done)
          begin
            // Count out the start-up delay
            if (count + 1'b1 >= burst_startup_delay)
            begin
              next_startup_done = 1'b1;
              next_count = '0;
              next_state = trig_mode ? RBS_ST_LOW : RBS_ST_HIGH; // Stream bursts at once
            end
            else
              next_count = count + 1'b1;
          end
          else if (trig_mode)
          begin
            // Burst only on a latched request after start-up
            next_count = '0;
            next_state = trig_pend ? RBS_ST_HIGH : RBS_ST_LOW;
            next_trig_pend = 1'b0;
          end
          else if (count + 1'b1 >= low_len)
          begin
            // Gapless switch to high phase
            next_state = RBS_ST_HIGH;
            next_count = '0;
          end
          else
            next_count = count + 1'b1;
        end
        RBS_ST_HIGH:
        begin
          if (count + 1'b1 >= (LEN_W+2)'(burst_phase_length))
          begin
            // Counter restarts at phase boundary
            next_state = RBS_ST_LOW;
            next_count = '0;
          end
          else
            next_count = count + 1'b1;
        end
        default: next_state = RBS_ST_OFF;
      endcase
      if (!enable)
        next_state = RBS_ST_OFF;
    end
    if (trig_req && startup_done && trig_mode) // Stall-proof request, set wins
      next_trig_pend = 1'b1;
  end
  // Sequencer state; reset delay of three minimum bursts, replaced by one low phase on enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state <= RBS_ST_OFF;
      count <= '0;
      startup_done <= 1'b0;
      trig_pend <= 1'b0;
      burst_startup_delay <= (LEN_W+2)'(`RBS_PWRUP_MULT) << `RBS_LEN_MIN_LOG2;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      startup_done <= next_startup_done;
      trig_pend <= next_trig_pend;
      burst_startup_delay <= next_burst_startup_delay;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Sample shaping and two-entry output buffer
  rbs_sample_s shaped;
  rbs_sample_s buf_mem [2];
  logic [1:0] fill;
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] next_fill;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic push;
  logic pop;
  // Truncate to phase resolution
  always_comb
  begin
    shaped.high_res = (state == RBS_ST_HIGH);
    if (state == RBS_ST_HIGH && width14)
    begin
      shaped.data = adc_data;
      shaped.res_bits = 4'(`RBS_RES_HIGH);
    end
    else if (state == RBS_ST_HIGH)
    begin
      shaped.data = {adc_data[13:14-`RBS_RES_MID], 2'h0};
      shaped.res_bits = 4'(`RBS_RES_MID);
    end
    else
    begin
      shaped.data = {adc_data[13:14-`RBS_RES_LOW], 5'h00};
      shaped.res_bits = 4'(`RBS_RES_LOW);
    end
  end
  assign in_ready = (fill != 2'h2);
  assign push = in_ready && (state != RBS_ST_OFF);
  assign out_valid = (fill != 2'h0);
  assign pop = out_valid && out_ready;
  assign out_sample = buf_mem[rd_ptr];
  always_comb
  begin
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_fill = fill + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      fill <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      fill <= next_fill;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push)
      buf_mem[wr_ptr] <= shaped;
  end
endmodule
`default_nettype wire

// File: verification/rbs_sequencer_props.sv
// Checker for the sequencer's bus and sample ports.
// Assumes a master that holds each request until taken.
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_props
  import rbs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire rbs_sample_s out_sample
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Bus request steps
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_req_taken;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req_wait |=> s_req_taken)
    else $error("wait state not exactly one");
  a_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state at request start");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait while idle");
  a_unmapped_zero: assert property (s_req_taken ##0 avs_read && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_len_range: assert property (s_req_taken ##0 avs_read && avs_address == 4'h4 |->
    avs_readdata >= 32'h00000400 && avs_readdata <= 32'h02000000)
    else $error("length out of range");
  ////////////////////////////////////////////////////////////////
  // Sample word shape and stall behaviour
  a_low_nine: assert property (out_valid && !out_sample.high_res |->
    out_sample.res_bits == 4'h9 && out_sample.data[4:0] == 5'h00)
    else $error("low sample not 9 bits");
  a_high_width: assert property (out_valid && out_sample.high_res |->
    out_sample.res_bits inside {4'hC, 4'hE})
    else $error("high sample width wrong");
  a_mid_align: assert property (out_valid && out_sample.res_bits == 4'hC |->
    out_sample.data[1:0] == 2'h0) else $error("12-bit sample not aligned");
  a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("sample lost in stall");
endmodule
bind rbs_sequencer rbs_sequencer_props i_props (.sys_clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .out_valid, .out_ready, .out_sample);
`default_nettype wire

// File: verification/rbs_framer_model.sv
// Framer stand-in: a sample sink that stalls at random.
// Assumes the bench supplies stall and hold levels.
`timescale 1ns/1ps
`default_nettype none
module rbs_framer_model
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic hold,
  output logic out_ready
);
  logic next_ready;
  // Ready drops on a stall or a bench hold
  always_comb
  begin
    next_ready = !(stall || hold);
  end
  always_ff @(posedge sys_clk)
  begin
    out_ready <= srst ? 1'b0 : next_ready;
  end
endmodule
`default_nettype wire

// File: verification/rbs_sequencer_tb.sv
// Bench for the sequencer: registers, stream and trigger bursts.
// Assumes the framer model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_tb;
  import rbs_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] adc_data = 14'h0000;
  logic out_valid;
  logic out_ready;
  rbs_sample_s out_sample;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic [31:0] rnd = 32'h00003CFC;
  logic [31:0] q;
  logic [3:0] exp_q[$];
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  rbs_sequencer i_dut (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .adc_data, .out_valid, .out_ready, .out_sample);
  rbs_framer_model i_framer (.sys_clk, .srst, .stall, .hold, .out_ready);
  ////////////////////////////////////////////////////////////////
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_reg(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: reg %h expected %h", $time, got, e);
    end
  endtask
  task automatic check_smp(input logic [3:0] e);
    logic [4:0] m;
    m = (e == 4'h9) ? 5'h1F : ((e == 4'hC) ? 5'h03 : 5'h00);
    compares++;
    if (out_sample.res_bits !== e || out_sample.high_res !== (e != 4'h9)
      || (out_sample.data[4:0] & m) !== 5'h00)
    begin
      bad_count++;
      $display("mismatch at %0t: res %0d expected %0d", $time, out_sample.res_bits, e);
    end
  endtask
  // Avalon access held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic push(input int n, input logic [3:0] r);
    repeat (n) exp_q.push_back(r);
  endtask
  // Stop the sequencer and throw away what is left
  task automatic stop_drain();
    hold <= 1'b1;
    av(1'b1, 4'h0, 32'h00000000);
    repeat (8) @(posedge sys_clk);
    hold <= 1'b0;
    while (out_valid !== 1'b0)
      @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Random data and stalls, plus the hang limit
  always @(posedge sys_clk)
  begin
    rnd <= xs(rnd);
    adc_data <= rnd[13:0];
    stall <= rnd[20] & rnd[21];
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // Accepted samples against the oldest note
  always @(posedge sys_clk)
  begin
    if (!srst && out_valid === 1'b1 && out_ready === 1'b1 && exp_q.size() > 0)
      check_smp(exp_q.pop_front());
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    av(1'b0, 4'h0, 32'h0);
    check_reg(q, 32'h00000002);
    av(1'b0, 4'h8, 32'h0);
    check_reg(q, 32'h00000001);
    av(1'b1, 4'h1, 32'hFFFFFFFF);
    av(1'b0, 4'h1, 32'h0);
    check_reg(q, 32'h00000000);
    av(1'b1, 4'h4, 32'h00000005);
    av(1'b0, 4'h4, 32'h0);
    check_reg(q, 32'h00000400);
    av(1'b1, 4'h4, 32'h04000000);
    av(1'b0, 4'h4, 32'h0);
    check_reg(q, 32'h02000000);
    av(1'b1, 4'h4, 32'h00000400);
    // Stream, 14-bit: start-up delay of one low phase then 1:3 bursts
    push(3072, 4'h9);
    push(1024, 4'hE);
    push(3072, 4'h9);
    push(1024, 4'hE);
    av(1'b1, 4'h0, 32'h00000003);
    wait (exp_q.size() == 0);
    // Stream, 12-bit: restart delay of one low phase
    stop_drain();
    push(1024, 4'h9);
    push(1024, 4'hC);
    push(1024, 4'h9);
    push(1024, 4'hC);
    av(1'b1, 4'h0, 32'h00000001);
    wait (exp_q.size() == 0);
    // Trigger mode: early request ignored, later one honoured
    stop_drain();
    push(1024, 4'h9);
    av(1'b1, 4'h0, 32'h00000005);
    av(1'b1, 4'hC, 32'h00000001);
    wait (exp_q.size() == 0);
    hold <= 1'b1;
    repeat (8) @(posedge sys_clk);
    // Two buffered low samples, then the one taken with the request
    push(3, 4'h9);
    push(1024, 4'hC);
    push(8, 4'h9);
    av(1'b1, 4'hC, 32'h00000001);
    hold <= 1'b0;
    wait (exp_q.size() == 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
